// *** imeg_pkg.sv ***
// Purpose: shared constants and carriers for the interleaved memory gate
// Assumes: 10 MHz single clock
// Notes:   request and response groups travel as packed structs
package imeg_pkg;
  // address and data widths
  localparam int ADDR_W          = 32;
  localparam int DATA_W          = 32;
  // request type and option code for an emulator access
  localparam logic [1:0] REQ_TYPE_MEM = 2'h0;
  localparam logic [2:0] OPT_EMU      = 3'h6;
  // default bank count and per-bank access latency in cycles
  localparam int NUM_BANKS       = 2;
  localparam int BANK_LAT        = 2;
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

  // request from the processor side
  typedef struct packed {
    logic              start;      // new request, fresh address
    logic              burst;      // burst continuation wanted
    logic              write;      // write when high
    logic [1:0]        req_type;   // request type code
    logic [2:0]        opt;        // option code
    logic [ADDR_W-1:0] addr;       // word byte address
    logic [DATA_W-1:0] wdata;      // write data
  } imeg_req_s;

  // response toward the processor
  typedef struct packed {
    logic              ready;      // word delivered
    logic              error;      // error answer
    logic              drive;      // data lines driven
    logic [DATA_W-1:0] rdata;      // read data
  } imeg_rsp_s;

  // controller states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INIT  = 2'b01,
    ST_BURST = 2'b10,
    ST_EMU   = 2'b11
  } imeg_state_e;
endpackage

// *** imeg_buf.sv ***
// Purpose: two-entry valid/ready buffer on the read data path
// Assumes: single clock, source and sink synchronous
// Notes:   full means two words held; in_ready falls then
`timescale 1ns/100ps
`default_nettype none
module imeg_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];   // storage
  logic [PW-1:0]    wp_ff, nxt_wp;    // write index
  logic [PW-1:0]    rp_ff, nxt_rp;    // read index
  logic [PW:0]      cnt_ff, nxt_cnt;  // fill count
  logic             push, pop;

  // handshake terms
  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    nxt_wp  = push ? ((wp_ff == PW'(DEPTH-1)) ? '0 : wp_ff + 1'b1) : wp_ff;
    nxt_rp  = pop ? ((rp_ff == PW'(DEPTH-1)) ? '0 : rp_ff + 1'b1) : rp_ff;
    nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
  end

  assign in_ready  = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];

  // index and count registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// *** imeg_gate.sv ***
// Purpose: interleaved bank controller with emulator takeover gate
// Assumes: inputs synchronous to clock; bursts never cross 1K or mix r/w
// Notes:   top outputs registered except req_stall, decoded from the buffer count; response is OR of bank answers
// Notes on behaviour
// - even words in bank zero, odd in bank one
// - banks started alternately, two cycles each access
// - bank count is a parameter, latency only first
// - non-sequential access restarts a full initial access
// - burst beats addressed from own counter
// - registered per-bank responses OR-combined
// - single-bank chip enable registered, not gated by clock
// - takeover pin disables all memory selection
// - type 00 and option 110 means emulator
// - emulator owns buses, no memory answers
// - decode needs type 00 beside option code
// - data driven only with ready or error
`timescale 1ns/100ps
`default_nettype none
module imeg_gate #(
  parameter int NUM_BANKS = imeg_pkg::NUM_BANKS,
  parameter int BANK_LAT  = imeg_pkg::BANK_LAT,
  parameter int DATA_W    = imeg_pkg::DATA_W,
  parameter int ADDR_W    = imeg_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // processor request
  input  wire imeg_pkg::imeg_req_s      req,
  input  wire logic                     emu_takeover,
  input  wire logic                     rsp_accept,
  // bank array side
  output logic [NUM_BANKS-1:0]          bank_ce,
  output logic                          bank_we,
  output logic [ADDR_W-1:0]             bank_addr,
  output logic [DATA_W-1:0]             bank_wdata,
  input  wire logic [NUM_BANKS*DATA_W-1:0] bank_rdata,
  // response to the processor
  output imeg_pkg::imeg_rsp_s           rsp,
  output logic                          req_stall
);
  localparam int BW = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
  localparam int LW = $clog2(BANK_LAT + 1);

  // bank index of a word address
  function automatic logic [BW-1:0] bank_of(input logic [ADDR_W-1:0] a);
    bank_of = BW'((a >> 2) % NUM_BANKS);
  endfunction

  // emulator access decode, type qualifies option
  function automatic logic is_emu(input imeg_pkg::imeg_req_s r, input logic pin);
    is_emu = pin || ((r.req_type == imeg_pkg::REQ_TYPE_MEM) &&
                     (r.opt == imeg_pkg::OPT_EMU));
  endfunction

  imeg_pkg::imeg_state_e st_ff, nxt_st;         // controller state
  logic [ADDR_W-1:0]     cnt_ff, nxt_cnt;       // burst address counter
  logic [ADDR_W-1:0]     lead_ff, nxt_lead;     // next bank start address
  logic [LW-1:0]         wait_ff, nxt_wait;     // initial latency count
  logic                  wr_ff, nxt_wr;         // burst direction
  logic [NUM_BANKS-1:0]  ce_ff, nxt_ce;         // bank starts
  logic [NUM_BANKS-1:0]  busy_ff [BANK_LAT];    // bank access pipe
  logic [NUM_BANKS-1:0]  done;                  // bank finishing now
  logic [DATA_W-1:0]     or_data;               // OR of bank answers
  logic                  emu_now;
  logic                  beat;
  logic                  buf_in_ready;
  logic                  buf_out_valid;
  logic [DATA_W-1:0]     buf_out_data;
  logic [DATA_W-1:0]     wdata_ff;
  logic                  rdy_ff, nxt_rdy;
  logic                  drv_ff, nxt_drv;
  logic [DATA_W-1:0]     rd_ff, nxt_rd;
  logic                  we_ff, nxt_we;
  logic [ADDR_W-1:0]     ba_ff, nxt_ba;
  logic [7:0]            pend;                  // words owed to the buffer

  assign emu_now = is_emu(req, emu_takeover);

  // per-bank access pipe, one stage per latency cycle
  generate
    for (genvar s = 0; s < BANK_LAT; s++) begin : g_pipe
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          busy_ff[s] <= '0;
        end else if (s == 0) begin
          busy_ff[s] <= ce_ff;
        end else begin
          busy_ff[s] <= busy_ff[s-1];
        end
      end
    end
  endgenerate

  assign done = busy_ff[BANK_LAT-1];

  // OR-combine read words of finishing banks
  always_comb begin
    or_data = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (done[b] && !wr_ff) begin
        or_data = or_data | bank_rdata[b*DATA_W +: DATA_W];
      end
    end
  end

  // read words queue here so a stall loses none
  imeg_buf #(
    .WIDTH (DATA_W),
    .DEPTH (2)
  ) u_buf (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  ((|done) && !wr_ff && (st_ff != imeg_pkg::ST_EMU)),
    .in_ready  (buf_in_ready),
    .in_data   (or_data),
    .out_valid (buf_out_valid),
    .out_ready (rsp_accept),
    .out_data  (buf_out_data)
  );

  // count buffered words plus every read still in the bank pipe,
  // so a start is made only when its word is sure of a slot
  always_comb begin
    pend = buf_in_ready ? (buf_out_valid ? 8'h1 : 8'h0) : 8'h2;
    if (buf_out_valid && rsp_accept) begin
      pend = pend - 8'h1;  // word leaving this cycle
    end
    pend = pend + 8'(|ce_ff);
    for (int s = 0; s < BANK_LAT; s++) begin
      pend = pend + 8'(|busy_ff[s]);
    end
  end

  // a bank may start only while its word will find room
  assign beat = wr_ff || (pend < 8'h2);

  // controller next state
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_lead = lead_ff;
    nxt_wait = wait_ff;
    nxt_wr   = wr_ff;
    nxt_ce   = '0;
    case (st_ff)
      imeg_pkg::ST_IDLE: begin
        if (req.start && emu_now) begin
          nxt_st = imeg_pkg::ST_EMU;
        end else if (req.start) begin
          nxt_cnt  = req.addr;        // fresh address taken
          nxt_lead = req.addr;
          nxt_wr   = req.write;
          nxt_wait = LW'(BANK_LAT);
          nxt_st   = imeg_pkg::ST_INIT;
        end
      end
      imeg_pkg::ST_INIT, imeg_pkg::ST_BURST: begin
        if (req.start && emu_now) begin
          nxt_st = imeg_pkg::ST_EMU;
        end else if (req.start) begin
          nxt_cnt  = req.addr;        // non-sequential restarts
          nxt_lead = req.addr;
          nxt_wr   = req.write;
          nxt_wait = LW'(BANK_LAT);
          nxt_st   = imeg_pkg::ST_INIT;
        end else if (!req.burst && (st_ff == imeg_pkg::ST_BURST)) begin
          nxt_st = imeg_pkg::ST_IDLE;
        end else if (beat) begin
          // start next bank, alternating by word
          nxt_ce[bank_of(lead_ff)] = 1'b1;
          nxt_lead = lead_ff + ADDR_W'(4);  // own counter
          if (!req.burst) begin
            nxt_st = imeg_pkg::ST_IDLE;  // single word, one access only
          end else if (wait_ff != '0) begin
            nxt_wait = wait_ff - 1'b1;
          end else begin
            nxt_st  = imeg_pkg::ST_BURST;
            nxt_cnt = cnt_ff + ADDR_W'(4);
          end
        end
      end
      imeg_pkg::ST_EMU: begin
        if (req.start && !emu_now) begin
          nxt_cnt  = req.addr;         // new request served at once
          nxt_lead = req.addr;
          nxt_wr   = req.write;
          nxt_wait = LW'(BANK_LAT);
          nxt_st   = imeg_pkg::ST_INIT;
        end
      end
      default: nxt_st = imeg_pkg::ST_IDLE;
    endcase
    if (emu_takeover) begin
      nxt_ce = '0;
    end
  end

  // output next values, data driven only with ready
  always_comb begin
    nxt_rdy = 1'b0;
    nxt_drv = 1'b0;
    nxt_rd  = '0;
    nxt_we  = 1'b0;
    nxt_ba  = ba_ff;
    if (|nxt_ce) begin
      nxt_ba = lead_ff;
      nxt_we = wr_ff;
    end
    if (st_ff == imeg_pkg::ST_EMU || emu_now) begin
      nxt_rdy = 1'b0;
    end else if (buf_out_valid && rsp_accept) begin
      nxt_rdy = 1'b1;
      nxt_drv = 1'b1;
      nxt_rd  = buf_out_data;
    end else if (wr_ff && (|done)) begin
      nxt_rdy = 1'b1;
    end
  end

  // registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff    <= imeg_pkg::ST_IDLE;
      cnt_ff   <= imeg_pkg::ADDR_RST;
      lead_ff  <= imeg_pkg::ADDR_RST;
      wait_ff  <= '0;
      wr_ff    <= 1'b0;
      ce_ff    <= '0;
      rdy_ff   <= 1'b0;
      drv_ff   <= 1'b0;
      rd_ff    <= '0;
      we_ff    <= 1'b0;
      ba_ff    <= imeg_pkg::ADDR_RST;
      wdata_ff <= '0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      lead_ff  <= nxt_lead;
      wait_ff  <= nxt_wait;
      wr_ff    <= nxt_wr;
      ce_ff    <= nxt_ce;
      rdy_ff   <= nxt_rdy;
      drv_ff   <= nxt_drv;
      rd_ff    <= nxt_rd;
      we_ff    <= nxt_we;
      ba_ff    <= nxt_ba;
      wdata_ff <= req.wdata;
    end
  end

  // chip enables registered on the clock edge; with one bank the enable
  // stays high through back-to-back starts, no per-clock gating
  assign bank_ce    = ce_ff;
  assign bank_we    = we_ff;
  assign bank_addr  = ba_ff;
  assign bank_wdata = wdata_ff;
  assign req_stall  = ~buf_in_ready;
  always_comb begin
    rsp.ready = rdy_ff;
    rsp.error = 1'b0;
    rsp.drive = drv_ff;
    rsp.rdata = rd_ff;
  end

  // checks
  drive_ready_a: assert property (@(posedge clock) disable iff (!rst_b)
    rsp.drive |-> rsp.ready) else $error("data driven without ready");
  emu_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
    (st_ff == imeg_pkg::ST_EMU) |-> !rsp.ready && (bank_ce == '0))
    else $error("memory answered during emulator access");
  pin_off_a: assert property (@(posedge clock) disable iff (!rst_b)
    emu_takeover |=> (bank_ce == '0)) else $error("bank selected under takeover");
  emu_dec_a: assert property (@(posedge clock) disable iff (!rst_b)
    (st_ff == imeg_pkg::ST_IDLE && req.start && req.req_type == 2'h0 && req.opt == 3'h6)
    |=> (st_ff == imeg_pkg::ST_EMU)) else $error("emulator code missed");
  type_qual_a: assert property (@(posedge clock) disable iff (!rst_b)
    (st_ff == imeg_pkg::ST_IDLE && req.start && !emu_takeover && req.req_type != 2'h0)
    |=> (st_ff == imeg_pkg::ST_INIT)) else $error("option decoded without type");
  one_bank_a: assert property (@(posedge clock) disable iff (!rst_b)
    $onehot0(bank_ce)) else $error("two banks started at once");
  seq_addr_a: assert property (@(posedge clock) disable iff (!rst_b)
    (|bank_ce) && $past(|bank_ce) && !$past(req.start, 2) |->
    (bank_addr == $past(bank_addr) + 32'h4)) else $error("counter not stepping");
  even_odd_a: assert property (@(posedge clock) disable iff (!rst_b)
    (|bank_ce) |-> bank_ce[bank_of(bank_addr)]) else $error("word in wrong bank");
  restart_a: assert property (@(posedge clock) disable iff (!rst_b)
    (req.start && !emu_now) |=> (st_ff == imeg_pkg::ST_INIT))
    else $error("new request did not restart");
  emu_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (st_ff == imeg_pkg::ST_EMU && !req.start) |=> (st_ff == imeg_pkg::ST_EMU))
    else $error("left emulator idle early");
endmodule
`default_nettype wire

// *** imeg_bank_model.sv ***
// Purpose: behavioural bank array on the far side of the gate
// Assumes: one word per bank start, answer held BANK_LAT+1 cycles
// Notes:   stale read lines toggle each cycle, so a late sample matches only on alternate cycles
`timescale 1ns/100ps
`default_nettype none
module imeg_bank_model #(
  parameter int NB  = 2,
  parameter int LAT = 2
) (
  // clock
  input  wire logic             clock,
  // bank control
  input  wire logic [NB-1:0]    bank_ce,
  input  wire logic             bank_we,
  input  wire logic [31:0]      bank_addr,
  input  wire logic [31:0]      bank_wdata,
  // read words
  output logic [NB*32-1:0]      bank_rdata
);
  logic [31:0] mem_ff [64];  // small word store
  logic [31:0] word_ff [NB]; // word on each bank's lines
  int          left_ff [NB]; // cycles the word still stands
  // known contents before any write
  initial begin
    for (int i = 0; i < 64; i++) mem_ff[i] = 32'hA5C3_0000 | 32'(i);
    for (int b = 0; b < NB; b++) begin
      word_ff[b] = 32'h0;
      left_ff[b] = 0;
    end
  end
  // start, hold, then spoil each bank's answer
  always @(posedge clock) begin
    for (int b = 0; b < NB; b++) begin
      if (bank_ce[b]) begin
        if (bank_we) mem_ff[bank_addr[7:2]] <= bank_wdata;
        word_ff[b] <= mem_ff[bank_addr[7:2]];
        left_ff[b] <= LAT;
      end else if (left_ff[b] > 0) begin
        left_ff[b] <= left_ff[b] - 1;
      end else begin
        word_ff[b] <= ~word_ff[b]; // hold time over
      end
    end
  end
  // pack bank words
  always_comb begin
    for (int b = 0; b < NB; b++) bank_rdata[b*32 +: 32] = word_ff[b];
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the interleaved memory gate
// Assumes: processor side driven here, bank array by the model
// Notes:   expected words come from a shadow of the model store
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                clock, rst_b, emu_takeover, rsp_accept, req_stall, bank_we;
  imeg_pkg::imeg_req_s req;        // processor request
  imeg_pkg::imeg_rsp_s rsp;        // response to processor
  logic [1:0]          bank_ce;    // bank starts
  logic [31:0]         bank_addr, bank_wdata;
  logic [63:0]         bank_rdata; // both banks' words
  logic [31:0]         shadow [64]; // expected store
  logic [31:0]         exp_q [$];   // words owed
  logic [31:0]         next_addr;   // next bank address
  logic                stall_seen;
  logic                bank_we_ack; // last request was a write
  int                  bad_count, comparisons, cycles, ce_seen, rdy_seen, b0, c0;

  imeg_gate dut_u (.clock(clock), .rst_b(rst_b), .req(req), .emu_takeover(emu_takeover),
    .rsp_accept(rsp_accept), .bank_ce(bank_ce), .bank_we(bank_we), .bank_addr(bank_addr),
    .bank_wdata(bank_wdata), .bank_rdata(bank_rdata), .rsp(rsp), .req_stall(req_stall));
  imeg_bank_model bank_u (.clock(clock), .bank_ce(bank_ce), .bank_we(bank_we),
    .bank_addr(bank_addr), .bank_wdata(bank_wdata), .bank_rdata(bank_rdata));

  // free-running clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // counts and verdict
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one-cycle start with fresh address
  task automatic request(input logic [31:0] a, input logic bu, input logic wr,
                         input logic [4:0] code);
    req.start    <= 1'b1;
    req.burst    <= bu;
    req.write    <= wr;
    req.req_type <= code[4:3];
    req.opt      <= code[2:0];
    req.addr     <= a;
    req.wdata    <= ~a;
    bank_we_ack  = wr;
    if (wr) shadow[a[7:2]] = ~a;
    @(posedge clock);
    req.start <= 1'b0;
  endtask

  // wait for n more words, bounded
  task automatic wait_words(input int n);
    int base = rdy_seen;
    int lim = 0;
    while (rdy_seen < base + n && lim < 200) begin
      @(posedge clock);
      lim++;
    end
    check("word count", 32'(base + n), 32'(rdy_seen));
  endtask

  // end burst, let words drain, all owed words delivered
  task automatic drain();
    req.burst <= 1'b0;
    repeat (12) @(posedge clock);
    check("words left", 32'h0, 32'(exp_q.size()));
  endtask

  // bus monitor
  always @(posedge clock) begin
    cycles++;
    if (rst_b && bank_ce !== 2'h0) begin
      ce_seen++;
      check("bank address", next_addr, bank_addr);
      check("bank select", 32'(2'h1 << next_addr[2]), 32'(bank_ce));
      if (!bank_we) exp_q.push_back(shadow[next_addr[7:2]]);
      next_addr = next_addr + 32'h4;
    end
    if (rst_b && req.start) next_addr = req.addr;
    if (rsp.ready === 1'b1) begin
      rdy_seen++;
      // a write answer carries no word; a read answer must
      if (rsp.drive === 1'b1 || !bank_we_ack)
        check("read word", exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_0000, rsp.rdata);
    end else begin
      check("idle lines", 32'h0, rsp.rdata | 32'({rsp.drive, rsp.error}));
    end
    if (req_stall === 1'b1) stall_seen = 1'b1;
    if (cycles > 6000) begin
      bad_count++;
      print_verdict();
    end
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    req = '0;
    emu_takeover = 1'b0;
    rsp_accept = 1'b1;
    stall_seen = 1'b0;
    bank_we_ack = 1'b0;
    next_addr = 32'h0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    ce_seen = 0;
    rdy_seen = 0;
    for (int i = 0; i < 64; i++) shadow[i] = 32'hA5C3_0000 | 32'(i);
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    request(32'h40, 1'b1, 1'b0, 5'h00);
    wait_words(6);
    drain();
    // write then non-sequential read back
    request(32'h84, 1'b0, 1'b1, 5'h00);
    wait_words(1);
    drain();
    request(32'h84, 1'b0, 1'b0, 5'h00);
    wait_words(1);
    drain();
    // receiver stalls from the start of a burst
    rsp_accept <= 1'b0;
    request(32'h00, 1'b1, 1'b0, 5'h00);
    repeat (12) @(posedge clock);
    check("stall seen", 32'h1, 32'(stall_seen));
    rsp_accept <= 1'b1;
    wait_words(6);
    drain();
    // every type and option code, only 00 with 110 is the emulator
    for (int k = 0; k < 32; k++) begin
      b0 = rdy_seen;
      c0 = ce_seen;
      request(32'(k) << 2, 1'b0, 1'b0, 5'(k));
      repeat (8) @(posedge clock);
      check("served words", (k == 6) ? 32'h0 : 32'h1, 32'(rdy_seen - b0));
      check("bank starts", (k == 6) ? 32'h0 : 32'h1, 32'(ce_seen - c0));
    end
    // takeover pin holds every bank off
    b0 = rdy_seen;
    c0 = ce_seen;
    emu_takeover <= 1'b1;
    request(32'h20, 1'b1, 1'b0, 5'h00);
    repeat (10) @(posedge clock);
    check("pin words", 32'h0, 32'(rdy_seen - b0 + ce_seen - c0));
    emu_takeover <= 1'b0;
    drain();
    request(32'h20, 1'b0, 1'b0, 5'h00);
    wait_words(1);
    drain();
    print_verdict();
  end
endmodule
`default_nettype wire
